/* src/scpr_pkg.sv */
// ==========================================================
// Shared constants of the serial control port.
package scpr_pkg;
   // ==========================================================
   // Frame layout.
   localparam int SCPR_ADDR_W     = 7;
   localparam int SCPR_DATA_W     = 8;
   localparam int SCPR_FRAME_BITS = 16;
   localparam logic [4:0] SCPR_RW_IDX   = 5'h07;   // Bit count at the direction bit.
   localparam logic [4:0] SCPR_LAST_IDX = 5'h0F;   // Bit count at a byte's last bit.
   localparam logic [4:0] SCPR_DATA_IDX = 5'h08;   // Bit count at a byte's first bit.
   // ==========================================================
   // Device register map and fields.
   localparam logic [6:0] SCPR_CLKDIV_ADDR = 7'h00;
   localparam logic [6:0] SCPR_LOOP_ADDR   = 7'h03;
   localparam int SCPR_CONV_DIV_LSB = 6;
   localparam int SCPR_CLK2_LSB   = 4;
   localparam int SCPR_CLK1_LSB   = 2;
   localparam int SCPR_SRCSEL_LSB = 0;
   localparam int SCPR_OUT_SEL_BIT = 0;
   localparam logic [7:0] SCPR_CLKDIV_RST = 8'h00;
   localparam logic [7:0] SCPR_LOOP_RST   = 8'h00;
   // ==========================================================
   // Host register map (AXI4-Lite byte offsets) and fields.
   localparam logic [3:0] SCPR_CMD_OFS  = 4'h0;
   localparam logic [3:0] SCPR_TXD_OFS  = 4'h4;
   localparam logic [3:0] SCPR_RXD_OFS  = 4'h8;
   localparam logic [3:0] SCPR_STAT_OFS = 4'hC;
   localparam int SCPR_CMD_RW_BIT  = 7;
   localparam int SCPR_CMD_CNT_LSB = 8;
   localparam int SCPR_STAT_BUSY   = 0;
   localparam int SCPR_STAT_DONE   = 1;
   localparam logic [1:0] SCPR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SCPR_RESP_SLVERR = 2'h2;
   // ==========================================================
   // Timing.
   localparam int SCPR_CLK_PERIOD_NS = 10;
   localparam int SCPR_SCLK_HALF_NS  = 80;
   localparam int SCPR_SCLK_HALF_CYC = (SCPR_SCLK_HALF_NS + SCPR_CLK_PERIOD_NS - 1) / SCPR_CLK_PERIOD_NS;
   // ==========================================================
   // Host engine states, Gray coded along the frame.
   typedef enum logic [1:0] {
      SCPR_IDLE  = 2'h0,
      SCPR_SETUP = 2'h1,
      SCPR_HIGH  = 2'h3,
      SCPR_LOW   = 2'h2
   } scpr_host_state_type;
endpackage

/* src/scpr_if.sv */
`timescale 1ns/100ps
// ==========================================================
// The four-wire control link between host and device.
interface scpr_if;
   logic ctrl_frame_select_n;
   logic ctrl_serial_clock;
   logic ctrl_serial_in;
   logic dev_out;
   logic dev_out_en;
   logic ctrl_serial_out;
   // The shared output line is pulled high while the device releases it.
   assign ctrl_serial_out = dev_out_en ? dev_out : 1'b1;
   modport host (output ctrl_frame_select_n, output ctrl_serial_clock, output ctrl_serial_in,
                 input ctrl_serial_out);
   modport dev  (input ctrl_frame_select_n, input ctrl_serial_clock, input ctrl_serial_in,
                 output dev_out, output dev_out_en);
endinterface

/* src/scpr_sync3.sv */
`timescale 1ns/100ps
// ==========================================================
// Three-stage input synchroniser; the output follows once stages two and three agree.
module scpr_sync3 (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic din,
   output logic      dout
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic dout_reg;

   // Stage one feeds stage two only, so metastability never reaches a decision.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg   <= 1'b1;
         s2_reg   <= 1'b1;
         s3_reg   <= 1'b1;
         dout_reg <= 1'b1;
      end else if (ce) begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            dout_reg <= s3_reg;
         end
      end
   end

   assign dout = dout_reg;
endmodule

/* src/scpr_dev.sv */
`timescale 1ns/100ps
// ==========================================================
// Device end: serial control port slave with its registers.
// Function
// - Every control register is eight bits wide.
// - Host writes zero into reserved bits.
// - One frame is sixteen serial clocks.
// - Frame starts and count restarts on select fall.
// - Seven address bits, then direction bit.
// - Direction low stores next eight bits.
// - Direction high shifts register out, eight clocks.
// - Input data ignored during a read.
// - Host holds select low for block transfers.
// - Block write increments address per byte.
// - Block read increments address per byte.
// - Bits 5:4, 3:2 divide internal clocks.
// - Bits 1:0 select converter master source.
// - Register 0x03 bit 0 selects loopback.
module scpr_dev
   import scpr_pkg::*;
(
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic ce,
   scpr_if.dev       link,
   input  wire logic transmitter_out,
   input  wire logic digital_audio_in_pin,
   output logic [1:0] converter_master_divider,
   output logic [1:0] internal_clock_two_divider,
   output logic [1:0] internal_clock_one_divider,
   output logic [1:0] converter_master_source,
   output logic       digital_output_source_sel,
   output logic       digital_audio_out_pin
);
   logic [4:0]  pin_raw;
   logic [4:0]  pin_sync;
   logic        tx_s;
   logic        frame_n_s;
   logic        sclk_s;
   logic        sdi_s;
   logic        ain_s;
   logic        sclk_prev_reg;
   logic        sclk_rise;
   logic        sclk_fall;
   logic [4:0]  bit_cnt_reg;
   logic [6:0]  in_shift_reg;
   logic [6:0]  addr_reg;
   logic        rw_reg;
   logic [7:0]  out_shift_reg;
   logic        out_reg;
   logic        out_en_reg;
   logic [7:0]  clkdiv_reg;
   logic        loop_reg;
   logic        audio_out_reg;
   logic        at_rw;
   logic        at_last;
   logic [7:0]  wr_byte;
   logic [6:0]  addr_inc;

   // ==========================================================
   // Input synchronisers; every pin comes from outside the mclk domain.
   assign pin_raw = {transmitter_out, digital_audio_in_pin, link.ctrl_serial_in, link.ctrl_serial_clock,
                     link.ctrl_frame_select_n};

   for (genvar i = 0; i < 5; i++) begin : g_sync
      scpr_sync3 u_sync (
         .mclk   (mclk),
         .arst_n (arst_n),
         .ce     (ce),
         .din    (pin_raw[i]),
         .dout   (pin_sync[i])
      );
   end

   assign frame_n_s = pin_sync[0];
   assign sclk_s    = pin_sync[1];
   assign sdi_s     = pin_sync[2];
   assign ain_s     = pin_sync[3];
   assign tx_s      = pin_sync[4];

   // ==========================================================
   // Serial clock edges count only inside a frame.
   assign sclk_rise = sclk_s & ~sclk_prev_reg & ~frame_n_s;
   assign sclk_fall = ~sclk_s & sclk_prev_reg & ~frame_n_s;
   assign at_rw     = (bit_cnt_reg == SCPR_RW_IDX);
   assign at_last   = (bit_cnt_reg == SCPR_LAST_IDX);
   assign wr_byte   = {in_shift_reg, sdi_s};
   assign addr_inc  = addr_reg + 7'h01;

   // Read view of the map; unimplemented addresses and reserved bits read as zero.
   function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] cd, input logic lp);
      logic [7:0] v;
      v = 8'h00;
      if (a == SCPR_CLKDIV_ADDR) begin
         v = cd;
      end else if (a == SCPR_LOOP_ADDR) begin
         v[SCPR_OUT_SEL_BIT] = lp;
      end
      return v;
   endfunction

   // Previous serial clock level for edge detection.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_prev_reg <= 1'b0;
      end else if (ce) begin
         sclk_prev_reg <= sclk_s;
      end
   end

   // ==========================================================
   // Bit counter and input shifter. Holding the count at zero while select is high means
   // a partial byte is simply dropped, and the falling select edge starts a clean count.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bit_cnt_reg  <= 5'h00;
         in_shift_reg <= 7'h00;
      end else if (ce) begin
         if (frame_n_s) begin
            bit_cnt_reg <= 5'h00;
         end else if (sclk_rise) begin
            in_shift_reg <= {in_shift_reg[5:0], sdi_s};
            if (at_last) begin
               bit_cnt_reg <= SCPR_DATA_IDX;
            end else begin
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
         end
      end
   end

   // Address and direction are taken on the eighth rising edge; the address steps per byte.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         addr_reg <= 7'h00;
         rw_reg   <= 1'b0;
      end else if (ce) begin
         if (frame_n_s) begin
            rw_reg <= 1'b0;
         end else if (sclk_rise && at_rw) begin
            addr_reg <= in_shift_reg;
            rw_reg   <= sdi_s;
         end else if (sclk_rise && at_last) begin
            addr_reg <= addr_inc;
         end
      end
   end

   // ==========================================================
   // Register writes on the last bit of each byte of a write frame.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         clkdiv_reg <= SCPR_CLKDIV_RST;
         loop_reg   <= SCPR_LOOP_RST[SCPR_OUT_SEL_BIT];
      end else if (ce) begin
         if (sclk_rise && at_last && !rw_reg) begin
            if (addr_reg == SCPR_CLKDIV_ADDR) begin
               clkdiv_reg <= wr_byte;
            end
            if (addr_reg == SCPR_LOOP_ADDR) begin
               loop_reg <= wr_byte[SCPR_OUT_SEL_BIT];
            end
         end
      end
   end

   // ==========================================================
   // Read path: load on the direction bit or a byte's end, then shift out on falling edges.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         out_shift_reg <= 8'h00;
         out_reg       <= 1'b0;
         out_en_reg    <= 1'b0;
      end else if (ce) begin
         if (frame_n_s) begin
            out_en_reg <= 1'b0;
         end else if (sclk_rise && at_rw && sdi_s) begin
            out_shift_reg <= reg_read(in_shift_reg, clkdiv_reg, loop_reg);
         end else if (sclk_rise && at_last && rw_reg) begin
            out_shift_reg <= reg_read(addr_inc, clkdiv_reg, loop_reg);
         end else if (sclk_fall && rw_reg && bit_cnt_reg[3]) begin
            out_reg       <= out_shift_reg[7];
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            out_en_reg    <= 1'b1;
         end
      end
   end

   assign link.dev_out    = out_reg;
   assign link.dev_out_en = out_en_reg;

   // ==========================================================
   // Configuration fields toward the clock tree.
   assign converter_master_divider   = clkdiv_reg[SCPR_CONV_DIV_LSB +: 2];
   assign internal_clock_two_divider = clkdiv_reg[SCPR_CLK2_LSB +: 2];
   assign internal_clock_one_divider = clkdiv_reg[SCPR_CLK1_LSB +: 2];
   assign converter_master_source    = clkdiv_reg[SCPR_SRCSEL_LSB +: 2];
   assign digital_output_source_sel  = loop_reg;

   // Both sources are synchronised and the mux is registered, so the pin lags by five cycles.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         audio_out_reg <= 1'b0;
      end else if (ce) begin
         audio_out_reg <= loop_reg ? ain_s : tx_s;
      end
   end

   assign digital_audio_out_pin = audio_out_reg;
endmodule

/* src/scpr_host.sv */
`timescale 1ns/100ps
// ==========================================================
// Host end: frames the serial link on orders taken over AXI4-Lite.
module scpr_host
   import scpr_pkg::*;
#(
   parameter int HALF_CYC = SCPR_SCLK_HALF_CYC
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   scpr_if.host             link
);
   scpr_host_state_type state_reg;
   logic [7:0]  div_reg;
   logic [5:0]  bits_left_reg;
   logic [39:0] tx_reg;
   logic [31:0] rx_reg;
   logic [9:0]  cmd_reg;
   logic [31:0] txd_reg;
   logic        done_reg;
   logic        frame_n_reg;
   logic        sclk_reg;
   logic        sdo_reg;
   logic        ret_s;
   logic        aw_have_reg;
   logic        w_have_reg;
   logic [3:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_go;
   logic        start;
   logic        half_done;
   logic [31:0] wmask;
   logic [31:0] cmd_new;
   logic [39:0] tx_next;
   logic [5:0]  frame_bits;

   // The device output comes from a pin, so it passes the same synchroniser.
   scpr_sync3 u_sync_ctrl_serial_out (
      .mclk   (mclk),
      .arst_n (arst_n),
      .ce     (ce),
      .din    (link.ctrl_serial_out),
      .dout   (ret_s)
   );

   // ==========================================================
   // AXI4-Lite write channel: address and data captured in either order.
   assign awready = ~aw_have_reg & ~bvalid;
   assign wready  = ~w_have_reg & ~bvalid;
   assign wr_go   = aw_have_reg & w_have_reg & ~bvalid;
   for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b +: 8] = {8{w_strb_reg[b]}};
   end
   assign cmd_new = ({22'h00_0000, cmd_reg} & ~wmask) | (w_data_reg & wmask);
   assign start   = wr_go && (aw_addr_reg == SCPR_CMD_OFS) && w_strb_reg[0] && (state_reg == SCPR_IDLE);
   assign tx_next = {cmd_new[6:0], cmd_new[SCPR_CMD_RW_BIT], txd_reg[7:0], txd_reg[15:8],
                     txd_reg[23:16], txd_reg[31:24]};
   assign frame_bits = 6'(SCPR_FRAME_BITS) + {1'b0, cmd_new[SCPR_CMD_CNT_LSB +: 2], 3'b000};

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
         bvalid      <= 1'b0;
         bresp       <= SCPR_RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         if (wr_go) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            bvalid      <= 1'b1;
            bresp       <= (aw_addr_reg[1:0] == 2'b00) ? SCPR_RESP_OKAY : SCPR_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Command and data registers; a command written while busy is dropped.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_reg <= 10'h000;
         txd_reg <= 32'h0000_0000;
      end else if (ce && wr_go) begin
         if (aw_addr_reg == SCPR_CMD_OFS && state_reg == SCPR_IDLE) begin
            cmd_reg <= cmd_new[9:0];
         end
         if (aw_addr_reg == SCPR_TXD_OFS) begin
            txd_reg <= (txd_reg & ~wmask) | (w_data_reg & wmask);
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel, one cycle from address to data.
   assign arready = ~rvalid;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= SCPR_RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= SCPR_RESP_OKAY;
            unique case (araddr)
               SCPR_CMD_OFS:  rdata <= {22'h00_0000, cmd_reg};
               SCPR_TXD_OFS:  rdata <= txd_reg;
               SCPR_RXD_OFS:  rdata <= rx_reg;
               SCPR_STAT_OFS: rdata <= {30'h0000_0000, done_reg, state_reg != SCPR_IDLE};
               default: begin
                  rdata <= 32'h0000_0000;
                  rresp <= SCPR_RESP_SLVERR;
               end
            endcase
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Frame engine. Data changes on the falling serial clock and is sampled on the rising one.
   // The reply returns through two synchronisers, about nine cycles after a fall, so the bit
   // that stood at a rising edge is taken at the end of that high phase instead.
   assign half_done = (div_reg == 8'(HALF_CYC - 1));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg     <= SCPR_IDLE;
         div_reg       <= 8'h00;
         bits_left_reg <= 6'h00;
         tx_reg        <= 40'h00_0000_0000;
         rx_reg        <= 32'h0000_0000;
         frame_n_reg   <= 1'b1;
         sclk_reg      <= 1'b0;
         sdo_reg       <= 1'b0;
      end else if (ce) begin
         div_reg <= half_done ? 8'h00 : div_reg + 8'h01;
         unique case (state_reg)
            SCPR_IDLE: begin
               div_reg <= 8'h00;
               if (start) begin
                  frame_n_reg   <= 1'b0;
                  tx_reg        <= tx_next;
                  sdo_reg       <= tx_next[39];
                  bits_left_reg <= frame_bits;
                  state_reg     <= SCPR_SETUP;
               end
            end
            SCPR_SETUP, SCPR_LOW: begin
               if (half_done) begin
                  if (bits_left_reg == 6'h00) begin
                     frame_n_reg <= 1'b1;
                     state_reg   <= SCPR_IDLE;
                  end else begin
                     sclk_reg      <= 1'b1;
                     bits_left_reg <= bits_left_reg - 6'h01;
                     state_reg     <= SCPR_HIGH;
                  end
               end
            end
            SCPR_HIGH: begin
               if (half_done) begin
                  sclk_reg  <= 1'b0;
                  rx_reg    <= {rx_reg[30:0], ret_s};
                  tx_reg    <= {tx_reg[38:0], 1'b0};
                  sdo_reg   <= tx_reg[38];
                  state_reg <= SCPR_LOW;
               end
            end
         endcase
      end
   end

   // Done flag: the end of a frame wins over a clear in the same cycle.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         done_reg <= 1'b0;
      end else if (ce) begin
         if (state_reg == SCPR_LOW && half_done && bits_left_reg == 6'h00) begin
            done_reg <= 1'b1;
         end else if (wr_go && aw_addr_reg == SCPR_STAT_OFS && w_strb_reg[0] &&
                      w_data_reg[SCPR_STAT_DONE]) begin
            done_reg <= 1'b0;
         end
      end
   end

   assign link.ctrl_frame_select_n = frame_n_reg;
   assign link.ctrl_serial_clock   = sclk_reg;
   assign link.ctrl_serial_in      = sdo_reg;
endmodule

/* testbench/scpr_link_sva.sv */
`timescale 1ns/100ps
// ==========================================================
// Checker on the four wires between host and device.
module scpr_link_sva (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ctrl_frame_select_n,
   input wire logic ctrl_serial_clock,
   input wire logic ctrl_serial_in,
   input wire logic dev_out,
   input wire logic dev_out_en
);
   logic [5:0] rise_cnt;
   logic       rw_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Count serial clock rises in a frame; the eighth rise carries the direction bit.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rise_cnt <= 6'h00;
         rw_q     <= 1'b0;
      end else if (ctrl_frame_select_n) begin
         rise_cnt <= 6'h00;
         rw_q     <= 1'b0;
      end else if ($rose(ctrl_serial_clock)) begin
         rise_cnt <= rise_cnt + 6'h01;
         if (rise_cnt == 6'h07) rw_q <= ctrl_serial_in;
      end
   end
   // ==========================================================
   // Wire assertions; the half period is the bench's eight cycles.
   a_clock_idle_low: assert property (ctrl_frame_select_n |-> !ctrl_serial_clock)
      else $error("serial clock high outside a frame");
   a_first_rise: assert property ($fell(ctrl_frame_select_n) |-> !ctrl_serial_clock [*8] ##1 ctrl_serial_clock)
      else $error("first serial clock rise misplaced");
   a_half_period: assert property ($rose(ctrl_serial_clock) |-> ctrl_serial_clock [*8] ##1 !ctrl_serial_clock)
      else $error("serial clock high phase wrong");
   a_whole_bytes: assert property ($rose(ctrl_frame_select_n) |-> rise_cnt >= 6'h10 && rise_cnt[2:0] == 3'h0)
      else $error("frame not sixteen bits plus whole bytes");
   a_data_at_fall: assert property (!ctrl_frame_select_n && $past(!ctrl_frame_select_n) && $changed(ctrl_serial_in)
      |-> $fell(ctrl_serial_clock))
      else $error("serial input changed away from a falling edge");
   a_out_steady: assert property (ctrl_serial_clock && $past(ctrl_serial_clock) && dev_out_en |-> $stable(dev_out))
      else $error("device output moved while clock high");
   a_drive_on_read: assert property ($rose(dev_out_en) |-> rw_q && rise_cnt >= 6'h08)
      else $error("device drove output without a read");
   a_release_out: assert property (ctrl_frame_select_n [*8] |-> !dev_out_en)
      else $error("device output not released");
   c_read: cover property ($rose(dev_out_en));
   c_block: cover property ($rose(ctrl_frame_select_n) && rise_cnt == 6'h28);
   c_start: cover property ($fell(ctrl_frame_select_n));
endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; $display("[FAIL] %0t got %h want %h", $time, a, e); end end
// ==========================================================
// Bench: AXI4-Lite orders to the host, device on the far end of the link.
module tb
   import scpr_pkg::*;
;
   logic        mclk = 1'b0;
   logic        arst_n = 1'b0;
   logic [3:0]  awaddr = 4'h0;
   logic [3:0]  araddr = 4'h0;
   logic [3:0]  wstrb = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        tx_src = 1'b0, dir_pin = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, out_sel, out_pin;
   wire [1:0]   bresp, rresp, div_m, div2, div1, msrc;
   wire [31:0]  rdata;
   wire [7:0]   cfg = {div_m, div2, div1, msrc};
   logic [31:0] rd;
   logic [1:0]  rs;
   int          failures = 0;
   int          tests_run = 0;
   // Free-running system clock.
   always #5 mclk = ~mclk;
   scpr_if scpr_if_i ();
   scpr_host #(.HALF_CYC(8)) scpr_host_i (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(scpr_if_i.host));
   scpr_dev scpr_dev_i (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .link(scpr_if_i.dev), .transmitter_out(tx_src),
      .digital_audio_in_pin(dir_pin), .converter_master_divider(div_m), .internal_clock_two_divider(div2),
      .internal_clock_one_divider(div1), .converter_master_source(msrc), .digital_output_source_sel(out_sel),
      .digital_audio_out_pin(out_pin));
   scpr_link_sva scpr_link_sva_i (.mclk(mclk), .arst_n(arst_n), .ctrl_frame_select_n(scpr_if_i.ctrl_frame_select_n),
      .ctrl_serial_clock(scpr_if_i.ctrl_serial_clock), .ctrl_serial_in(scpr_if_i.ctrl_serial_in),
      .dev_out(scpr_if_i.dev_out), .dev_out_en(scpr_if_i.dev_out_en));
   // ==========================================================
   // Bus tasks; every wait is bounded so a stuck slave ends the run.
   task automatic end_sim;
      $display("Checks %0d, failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      rs = bresp;
      bready <= 1'b0;
      if (n >= 50) begin failures++; end_sim(); end
   endtask
   task automatic axr(input logic [3:0] a);
      int n;
      n = 0;
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n >= 50) begin failures++; end_sim(); end
   endtask
   // Poll the sticky done flag, then clear it by writing one.
   task automatic wait_done;
      int n;
      n = 0;
      do begin
         axr(SCPR_STAT_OFS);
         n++;
      end while (rd[SCPR_STAT_DONE] !== 1'b1 && n < 400);
      if (n >= 400) begin failures++; end_sim(); end
      axw(SCPR_STAT_OFS, 32'h0000_0002);
   endtask
   task automatic frame(input logic [31:0] txd, input logic [9:0] cmd);
      axw(SCPR_TXD_OFS, txd);
      axw(SCPR_CMD_OFS, {22'h00_0000, cmd});
      wait_done();
   endtask
   // ==========================================================
   // Main sequence; the synchronisers need a few edges after reset.
   initial begin
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK(cfg, 8'h00)
      for (int i = 0; i < 4; i++) begin
         frame({24'h00_0000, 8'h55 * i[7:0]}, 10'h000);
         `CHK(cfg, 8'h55 * i[7:0])
      end
      frame(32'h0100_00B4, 10'h300);
      `CHK(cfg, 8'hB4)
      `CHK(out_sel, 1'b1)
      dir_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      `CHK(out_pin, 1'b1)
      frame(32'hFFFF_FFFF, 10'h380);
      axr(SCPR_RXD_OFS);
      `CHK(rd, 32'hB400_0001)
      `CHK(cfg, 8'hB4)
      frame(32'h0000_0000, 10'h003);
      `CHK(out_sel, 1'b0)
      tx_src <= 1'b1;
      dir_pin <= 1'b0;
      repeat (8) @(posedge mclk);
      `CHK(out_pin, 1'b1)
      frame(32'h0000_0000, 10'h080);
      axr(SCPR_RXD_OFS);
      `CHK(rd[7:0], 8'hB4)
      frame(32'h0000_2700, 10'h17F);
      `CHK(cfg, 8'h27)
      // A second order while the link is busy must be dropped.
      axw(SCPR_TXD_OFS, 32'h0000_0011);
      axw(SCPR_CMD_OFS, 32'h0000_0000);
      axw(SCPR_CMD_OFS, 32'h0000_0003);
      wait_done();
      `CHK(cfg, 8'h11)
      `CHK(out_sel, 1'b0)
      axr(SCPR_STAT_OFS);
      `CHK(rd[SCPR_STAT_DONE], 1'b0)
      axr(4'h2);
      `CHK(rs, SCPR_RESP_SLVERR)
      axw(4'h6, 32'h0000_0001);
      `CHK(rs, SCPR_RESP_SLVERR)
      end_sim();
   end
endmodule
